/* logic/ppm_pkg.sv */
// Purpose: constants for the port 2 pin function selector
// Assumes: timer field encodings as used by the pulse timer unit
// Notes: mode and io-control codes are 4 bits, clear source 3 bits for channel 3 and 2 bits for channels 4 and 5
package ppm_pkg;
    // ------------------------------------------------------------
    // timer mode codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_PWM1 = 4'h2;
    localparam logic [3:0] MODE_PWM2 = 4'h3;
    // ------------------------------------------------------------
    // pwm mode 2 clear-source exceptions per pin
    // ------------------------------------------------------------
    localparam logic [2:0] CLR_P0 = 3'h1;
    localparam logic [2:0] CLR_P1 = 3'h2;
    localparam logic [2:0] CLR_P2 = 3'h5;
    localparam logic [2:0] CLR_P3 = 3'h6;
    localparam logic [1:0] CLR_CHA = 2'h1;
    localparam logic [1:0] CLR_CHB = 2'h2;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DRAIN_RST = 8'h00;
    localparam logic [7:0] PIN_RST = 8'h00;
endpackage : ppm_pkg

/* logic/ppm_port2_mux.sv */
// Purpose: pin function selector for the eight lines of port 2
// Assumes: control fields come from registers on i_sys_clk
// Notes: pins 0-2 follow variant A, pins 3-7 variant B
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1 - pin1 carries t3 channel B output
// RQ2 - pin0 carries t3 channel A output
// RQ3 - pin2 feeds or drives t3 channel C
// RQ4 - pwm1 C kills D; buffer frees pin2
// RQ5 - no timer: direction, latch or pattern
// RQ6 - pattern reaches pins when route 0
// RQ7 - timer reaches pins when route 0
// RQ8 - pins 0-2 feed alternate interrupts
// RQ9 - i2c lines always open drain
// RQ10 - i2c enable owns pins 7, 6
// RQ11 - pin7 capture/compare t5 channel B
// RQ12 - pin6 capture/compare t5 channel A
// RQ13 - pin6 feeds adc external trigger
// RQ14 - expanded: wait input owns pin5
// RQ15 - single-chip: pin5 ignores wait enable; code still honours it when i_external_bus_on is set
// RQ16 - pin5 drives byte timer 1 output
// RQ17 - pin4 byte timer0, rx, port order
// RQ18 - serial rx reaches pin4 when route 0
// RQ19 - pin3 drives serial transmit data
// RQ20 - pins 5,4 feed t4 captures
// RQ21 - pin3 feeds t3 D only mode 0000
// RQ22 - drain bit selects open-drain output
// RQ23 - selection registered, one cycle later
// RQ24 - other timer settings leave port control
module ppm_port2_mux (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // timer channel 3
    input wire logic [3:0] i_t3_mode,
    input wire logic [3:0] i_t3_io_a,
    input wire logic [3:0] i_t3_io_b,
    input wire logic [3:0] i_t3_io_c,
    input wire logic [3:0] i_t3_io_d,
    input wire logic [2:0] i_t3_clr,
    input wire logic i_t3_buf_a,
    input wire logic i_t3_buf_b,
    input wire logic [3:0] i_t3_out,
    // timer channels 4 and 5
    input wire logic [3:0] i_t4_mode,
    input wire logic [3:0] i_t4_io_a,
    input wire logic [3:0] i_t4_io_b,
    input wire logic [1:0] i_t4_clr,
    input wire logic [1:0] i_t4_out,
    input wire logic [3:0] i_t5_mode,
    input wire logic [3:0] i_t5_io_a,
    input wire logic [3:0] i_t5_io_b,
    input wire logic [1:0] i_t5_clr,
    input wire logic [1:0] i_t5_out,
    // port and pattern unit
    input wire logic [7:0] i_direction,
    input wire logic [7:0] i_latch,
    input wire logic [7:0] i_pattern_bit_enable,
    input wire logic [7:0] i_pattern_out,
    input wire logic [7:0] i_drain_select,
    // route selects
    input wire logic i_pattern_route_sel,
    input wire logic i_timer_route_sel,
    input wire logic i_byte_timer_route_sel,
    input wire logic i_wait_pin_route_sel,
    input wire logic i_rx4_route_sel,
    input wire logic [2:0] i_irq_route_sel,
    // byte timers, serial, i2c, adc, bus
    input wire logic [3:0] i_bt0_compare_out_sel,
    input wire logic [3:0] i_bt1_compare_out_sel,
    input wire logic [1:0] i_bytetimer_out,
    input wire logic i_sci4_rx_on,
    input wire logic i_sci4_tx_on,
    input wire logic i_serial4_tx_line,
    input wire logic i_iic2_enable,
    input wire logic i_scl_out,
    input wire logic i_sda_out,
    input wire logic i_adc_ext_trigger_sel,
    input wire logic [1:0] i_adc_trigger_sel,
    input wire logic i_single_chip_mode,
    input wire logic i_external_bus_on,
    input wire logic i_wait_pin_on,
    // pins
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin,
    output logic [7:0] o_pin_oe,
    // inputs delivered to peripherals
    output logic [3:0] o_t3_capture,
    output logic [1:0] o_t4_capture,
    output logic [1:0] o_t5_capture,
    output logic [2:0] o_ext_int_alt,
    output logic o_serial4_rx_line,
    output logic o_adc1_ext_trigger,
    output logic o_bus_wait,
    output logic o_scl_in,
    output logic o_sda_in
);
    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic [7:0] pin_s1_q;
    logic [7:0] pin_q;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_s1_q <= ppm_pkg::PIN_RST;
            pin_q <= ppm_pkg::PIN_RST;
        end else begin
            pin_s1_q <= i_pin;
            pin_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // timer ownership decode
    // ------------------------------------------------------------
    logic [7:0] tmr_own;
    logic [7:0] tmr_val;
    logic t3_nrm;
    logic t4_nrm;
    logic t5_nrm;
    logic t3_buf;
    logic t3c_pwm1;
    logic t3a_pwm1;
    logic t4a_pwm1;
    logic t5a_pwm1;
    // compare output io codes 0001-0011 and 0101-0111
    function automatic logic oc(input logic [3:0] io);
        oc = !io[3] && (io[1:0] != 2'h0);
    endfunction
    // capture io code 10xx
    function automatic logic cap(input logic [3:0] io);
        cap = (io[3:2] == 2'h2);
    endfunction
    always_comb begin
        t3_nrm = (i_t3_mode == ppm_pkg::MODE_NORMAL);
        t4_nrm = (i_t4_mode == ppm_pkg::MODE_NORMAL) ||
                 (i_t4_mode[3:2] == 2'h1);
        t5_nrm = (i_t5_mode == ppm_pkg::MODE_NORMAL) ||
                 (i_t5_mode[3:2] == 2'h1);
        t3_buf = i_t3_buf_a || i_t3_buf_b; // [RQ4]
        t3a_pwm1 = (i_t3_mode == ppm_pkg::MODE_PWM1) &&
                   (i_t3_io_a[1:0] != 2'h0);
        t3c_pwm1 = (i_t3_mode == ppm_pkg::MODE_PWM1) &&
                   (i_t3_io_c[1:0] != 2'h0);
        t4a_pwm1 = (i_t4_mode == ppm_pkg::MODE_PWM1) &&
                   (i_t4_io_a[1:0] != 2'h0);
        t5a_pwm1 = (i_t5_mode == ppm_pkg::MODE_PWM1) &&
                   (i_t5_io_a[1:0] != 2'h0);
        tmr_own = 8'h00;
        // pin 0: channel 3 A
        tmr_own[0] = (t3_nrm && oc(i_t3_io_a)) || t3a_pwm1 ||
            ((i_t3_mode == ppm_pkg::MODE_PWM2) &&
             (i_t3_io_a[1:0] != 2'h0) &&
             (i_t3_clr != ppm_pkg::CLR_P0)); // [RQ2]
        // pin 1: channel 3 B, off when A runs pwm mode 1
        tmr_own[1] = !t3a_pwm1 && ((t3_nrm && oc(i_t3_io_b)) ||
            ((i_t3_mode == ppm_pkg::MODE_PWM2) &&
             (i_t3_io_b[1:0] != 2'h0) &&
             (i_t3_clr != ppm_pkg::CLR_P1))); // [RQ1]
        // pin 2: channel 3 C, released in buffer mode
        tmr_own[2] = !t3_buf && ((t3_nrm && oc(i_t3_io_c)) ||
            t3c_pwm1 ||
            ((i_t3_mode == ppm_pkg::MODE_PWM2) &&
             (i_t3_io_c[1:0] != 2'h0) &&
             (i_t3_clr != ppm_pkg::CLR_P2))); // [RQ3] [RQ4]
        // pin 3: channel 3 D, off when C runs pwm mode 1
        tmr_own[3] = !t3c_pwm1 && ((t3_nrm && oc(i_t3_io_d)) ||
            ((i_t3_mode == ppm_pkg::MODE_PWM2) &&
             (i_t3_io_d[1:0] != 2'h0) &&
             (i_t3_clr != ppm_pkg::CLR_P3))); // [RQ4]
        // pin 4: channel 4 A
        tmr_own[4] = (t4_nrm && oc(i_t4_io_a)) || t4a_pwm1 ||
            ((i_t4_mode == ppm_pkg::MODE_PWM2) &&
             (i_t4_io_a[1:0] != 2'h0) &&
             (i_t4_clr != ppm_pkg::CLR_CHA));
        // pin 5: channel 4 B
        tmr_own[5] = !t4a_pwm1 && ((t4_nrm && oc(i_t4_io_b)) ||
            ((i_t4_mode == ppm_pkg::MODE_PWM2) &&
             (i_t4_io_b[1:0] != 2'h0) &&
             (i_t4_clr != ppm_pkg::CLR_CHB)));
        // pin 6: channel 5 A
        tmr_own[6] = (t5_nrm && oc(i_t5_io_a)) || t5a_pwm1 ||
            ((i_t5_mode == ppm_pkg::MODE_PWM2) &&
             (i_t5_io_a[1:0] != 2'h0) &&
             (i_t5_clr != ppm_pkg::CLR_CHA)); // [RQ12]
        // pin 7: channel 5 B
        tmr_own[7] = !t5a_pwm1 && ((t5_nrm && oc(i_t5_io_b)) ||
            ((i_t5_mode == ppm_pkg::MODE_PWM2) &&
             (i_t5_io_b[1:0] != 2'h0) &&
             (i_t5_clr != ppm_pkg::CLR_CHB))); // [RQ11]
        // route select gates every timer pin
        if (i_timer_route_sel) begin
            tmr_own = 8'h00; // [RQ7] [RQ24]
        end
        tmr_val = {i_t5_out, i_t4_out, i_t3_out};
    end

    // ------------------------------------------------------------
    // per-pin function choice
    // ------------------------------------------------------------
    logic [7:0] out_d;
    logic [7:0] oe_d;
    logic [7:0] od_d;
    logic wait_own;
    logic rx_own;
    always_comb begin
        wait_own = !i_single_chip_mode || i_external_bus_on;
        wait_own = wait_own && i_wait_pin_on &&
                   i_wait_pin_route_sel; // [RQ14] [RQ15]
        rx_own = i_sci4_rx_on && !i_rx4_route_sel; // [RQ18]
        od_d = i_drain_select; // [RQ22]
        for (int k = 0; k < 8; k++) begin
            // port latch or pattern unit by direction
            oe_d[k] = i_direction[k]; // [RQ5]
            out_d[k] = (i_pattern_bit_enable[k] &&
                        !i_pattern_route_sel) ?
                       i_pattern_out[k] : i_latch[k]; // [RQ5] [RQ6]
            if (tmr_own[k]) begin
                oe_d[k] = 1'b1;
                out_d[k] = tmr_val[k];
            end
        end
        // pin 3: serial transmit below the timer
        if (!tmr_own[3] && i_sci4_tx_on) begin
            oe_d[3] = 1'b1;
            out_d[3] = i_serial4_tx_line; // [RQ19]
        end
        // pin 4: byte timer 0, then serial receive
        if (!tmr_own[4]) begin
            if ((i_bt0_compare_out_sel != 4'h0) &&
                !i_byte_timer_route_sel) begin
                oe_d[4] = 1'b1;
                out_d[4] = i_bytetimer_out[0]; // [RQ17]
            end else if (rx_own) begin
                oe_d[4] = 1'b0; // [RQ17]
            end
        end
        // pin 5: byte timer 1 below the timer, wait on top
        if (!tmr_own[5] && (i_bt1_compare_out_sel != 4'h0) &&
            !i_byte_timer_route_sel) begin
            oe_d[5] = 1'b1;
            out_d[5] = i_bytetimer_out[1]; // [RQ16]
        end
        if (wait_own) begin
            oe_d[5] = 1'b0; // [RQ14]
        end
        // pins 7, 6: i2c owns both, always open drain
        if (i_iic2_enable) begin
            out_d[7] = 1'b0;
            out_d[6] = 1'b0;
            oe_d[7] = !i_scl_out; // [RQ10]
            oe_d[6] = !i_sda_out; // [RQ10]
            od_d[7] = 1'b1; // [RQ9]
            od_d[6] = 1'b1; // [RQ9]
        end
        // open drain: drive low only, release for high
        for (int k = 0; k < 8; k++) begin
            if (od_d[k] && out_d[k]) begin
                oe_d[k] = 1'b0; // [RQ22]
            end
        end
    end

    // ------------------------------------------------------------
    // registered pin drive
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin <= ppm_pkg::PIN_RST;
            o_pin_oe <= ppm_pkg::DRAIN_RST;
        end else begin
            o_pin <= out_d; // [RQ23]
            o_pin_oe <= oe_d; // [RQ23]
        end
    end

    // ------------------------------------------------------------
    // inputs to peripherals from synchronised pins
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_t3_capture <= 4'h0;
            o_t4_capture <= 2'h0;
            o_t5_capture <= 2'h0;
            o_ext_int_alt <= 3'h0;
            o_serial4_rx_line <= 1'b1;
            o_adc1_ext_trigger <= 1'b0;
            o_bus_wait <= 1'b0;
            o_scl_in <= 1'b1;
            o_sda_in <= 1'b1;
        end else begin
            o_t3_capture[0] <= pin_q[0] && t3_nrm && cap(i_t3_io_a) &&
                               !i_timer_route_sel;
            o_t3_capture[1] <= pin_q[1] && t3_nrm && cap(i_t3_io_b) &&
                               !i_timer_route_sel;
            o_t3_capture[2] <= pin_q[2] && t3_nrm && cap(i_t3_io_c) &&
                               !i_timer_route_sel; // [RQ3]
            o_t3_capture[3] <= pin_q[3] && t3_nrm && cap(i_t3_io_d) &&
                               !i_timer_route_sel; // [RQ21]
            o_t4_capture[0] <= pin_q[4] && t4_nrm && cap(i_t4_io_a) &&
                               !i_timer_route_sel; // [RQ20]
            o_t4_capture[1] <= pin_q[5] && t4_nrm && cap(i_t4_io_b) &&
                               !i_timer_route_sel; // [RQ20]
            o_t5_capture[0] <= pin_q[6] && t5_nrm && i_t5_io_a[3] &&
                               !i_timer_route_sel; // [RQ12]
            o_t5_capture[1] <= pin_q[7] && t5_nrm && i_t5_io_b[3] &&
                               !i_timer_route_sel; // [RQ11]
            o_ext_int_alt <= pin_q[2:0] & i_irq_route_sel; // [RQ8]
            o_serial4_rx_line <= rx_own ? pin_q[4] : 1'b1;
            o_adc1_ext_trigger <= pin_q[6] && !i_adc_ext_trigger_sel &&
                                  (i_adc_trigger_sel == 2'h3); // [RQ13]
            o_bus_wait <= wait_own && pin_q[5]; // [RQ14]
            o_scl_in <= i_iic2_enable ? pin_q[7] : 1'b1;
            o_sda_in <= i_iic2_enable ? pin_q[6] : 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_i2c_od;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_iic2_enable && i_scl_out |=> !o_pin_oe[7];
    endproperty
    a_i2c_od: assert property (p_i2c_od) else $error("scl driven"); // [RQ9]
    property p_wait;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        wait_own |=> !o_pin_oe[5];
    endproperty
    a_wait: assert property (p_wait) else $error("wait pin driven"); // [RQ14]
    property p_input;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !tmr_own[1] && !i_direction[1] |=> !o_pin_oe[1];
    endproperty
    a_input: assert property (p_input) else $error("input driven"); // [RQ5]
    property p_route;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_timer_route_sel && (i_direction[2:0] == 3'h0)
        |=> o_pin_oe[2:0] == 3'h0;
    endproperty
    a_route: assert property (p_route) else $error("timer leak"); // [RQ7]
    property p_buf;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        t3_buf && !i_direction[2] |=> !o_pin_oe[2];
    endproperty
    a_buf: assert property (p_buf) else $error("buffer pin2 owned"); // [RQ4]
    property p_irq;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_irq_route_sel[0] && pin_q[0] |=> o_ext_int_alt[0];
    endproperty
    a_irq: assert property (p_irq) else $error("irq alt lost"); // [RQ8]
    property p_tx;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        i_sci4_tx_on && !tmr_own[3] && !i_drain_select[3]
        |=> o_pin_oe[3] && o_pin[3] == $past(i_serial4_tx_line);
    endproperty
    a_tx: assert property (p_tx) else $error("tx not on pin3"); // [RQ19]
    property p_pwm1;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        t3a_pwm1 && !i_direction[1] |=> !o_pin_oe[1];
    endproperty
    a_pwm1: assert property (p_pwm1) else $error("pin1 in pwm1"); // [RQ2]
    c_i2c: cover property (@(posedge i_sys_clk) i_iic2_enable);
    c_wait: cover property (@(posedge i_sys_clk) wait_own);
    c_tmr: cover property (@(posedge i_sys_clk) tmr_own[0]);
endmodule : ppm_port2_mux
`default_nettype wire

/* test/ppm_periph_model.sv */
// Purpose: peripheral outputs seen by the port 2 pin selector
// Assumes: values change only when the bench asks for fresh ones
// Notes: i2c drive lines come out of reset released (high)
`timescale 1ns/10ps
`default_nettype none
module ppm_periph_model (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // request for new output values
    input wire logic i_shuffle,
    // peripheral outputs
    output logic [3:0] o_t3_out,
    output logic [1:0] o_t4_out,
    output logic [1:0] o_t5_out,
    output logic [7:0] o_pattern_out,
    output logic [1:0] o_bytetimer_out,
    output logic o_tx,
    output logic o_scl,
    output logic o_sda
);
    logic [31:0] rand_q;
    // new values on request only, so the bench can predict the pins
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rand_q <= 32'h0000_0003;
        end else if (i_shuffle) begin
            rand_q <= $urandom;
        end
    end
    // slices of the held word feed each peripheral output
    assign {o_sda, o_scl} = rand_q[1:0];
    assign o_tx = rand_q[2];
    assign o_bytetimer_out = rand_q[4:3];
    assign o_t3_out = rand_q[8:5];
    assign {o_t5_out, o_t4_out} = rand_q[12:9];
    assign o_pattern_out = rand_q[20:13];
endmodule : ppm_periph_model
`default_nettype wire

/* test/tb.sv */
// Purpose: self-checking bench for the port 2 pin selector
// Assumes: peripheral outputs come from ppm_periph_model
// Notes: each step waits four edges before results are sampled
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct {
        int kind;
        string name;
        logic [15:0] mask;
        logic [15:0] v;
        logic [15:0] e;
    } ppm_note_t;
    ppm_note_t notes[$];
    int bad_count = 0;
    int checked = 0;
    event sample_ev;
    logic i_sys_clk, i_reset_n, shuffle, i_t3_buf_a, i_t3_buf_b;
    logic [3:0] i_t3_mode, i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d;
    logic [3:0] i_t4_mode, i_t4_io_a, i_t4_io_b, i_t5_mode, i_t5_io_a;
    logic [3:0] i_t5_io_b, i_bt0_compare_out_sel, i_bt1_compare_out_sel;
    logic [3:0] i_t3_out, o_t3_capture;
    logic [2:0] i_t3_clr, i_irq_route_sel, o_ext_int_alt;
    logic [1:0] i_t4_clr, i_t5_clr, i_t4_out, i_t5_out, i_bytetimer_out;
    logic [1:0] i_adc_trigger_sel, o_t4_capture, o_t5_capture;
    logic [7:0] i_direction, i_latch, i_pattern_bit_enable, i_pattern_out;
    logic [7:0] i_drain_select, i_pin, ext, o_pin, o_pin_oe;
    logic i_pattern_route_sel, i_timer_route_sel, i_byte_timer_route_sel;
    logic i_wait_pin_route_sel, i_rx4_route_sel, i_sci4_rx_on, i_sci4_tx_on;
    logic i_serial4_tx_line, i_iic2_enable, i_scl_out, i_sda_out;
    logic i_adc_ext_trigger_sel, i_single_chip_mode, i_external_bus_on;
    logic i_wait_pin_on, o_serial4_rx_line, o_adc1_ext_trigger, o_bus_wait;
    logic o_scl_in, o_sda_in;
    logic [15:0] ins;
    logic [2:0] clr_tab [4];
    logic [3:0] oc_tab [6];
    // pin level: design drive where enabled, outside level elsewhere
    assign i_pin = (o_pin & o_pin_oe) | (ext & ~o_pin_oe);
    assign ins = {o_t3_capture[2:0], o_t4_capture[1], o_t5_capture[0],
                  o_sda_in, o_scl_in, o_t4_capture[0], o_t5_capture[1],
                  o_adc1_ext_trigger, o_bus_wait, o_serial4_rx_line,
                  o_t3_capture[3], o_ext_int_alt};
    ppm_port2_mux ppm_port2_mux_i (.*);
    ppm_periph_model ppm_periph_model_i (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_shuffle(shuffle),
        .o_t3_out(i_t3_out), .o_t4_out(i_t4_out), .o_t5_out(i_t5_out),
        .o_pattern_out(i_pattern_out), .o_bytetimer_out(i_bytetimer_out),
        .o_tx(i_serial4_tx_line), .o_scl(i_scl_out), .o_sda(i_sda_out)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic want(input int kind, input string nm,
                        input logic [15:0] mask, v, e);
        notes.push_back('{kind, nm, mask, v & mask, e & mask});
    endtask : want
    task automatic wp(input string nm, input logic [7:0] m, v, e);
        want(0, nm, {8'h00, m}, {8'h00, v}, {8'h00, e});
    endtask : wp
    task automatic wi(input string nm, input logic [15:0] m, v);
        want(1, nm, m, v, 16'h0000);
    endtask : wi
    task automatic miss(input string nm, input logic [15:0] x, y);
        checked++;
        if (x !== y) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, x, y);
        end
    endtask : miss
    task automatic cmp_pins(input ppm_note_t n);
        miss({n.name, "_oe"}, n.e, {8'h00, o_pin_oe} & n.mask);
        miss(n.name, n.v & n.e, {8'h00, o_pin} & n.e);
    endtask : cmp_pins
    task automatic cmp_ins(input ppm_note_t n);
        miss(n.name, n.v, ins & n.mask);
    endtask : cmp_ins
    task automatic settle;
        repeat (4) @(posedge i_sys_clk);
        #10;
        -> sample_ev;
        @(negedge i_sys_clk);
    endtask : settle
    task automatic clear;
        {i_t3_mode, i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d, i_t3_clr,
         i_t3_buf_a, i_t3_buf_b, i_t4_mode, i_t4_io_a, i_t4_io_b, i_t4_clr,
         i_t5_mode, i_t5_io_a, i_t5_io_b, i_t5_clr, i_direction,
         i_pattern_bit_enable, i_drain_select, i_pattern_route_sel,
         i_timer_route_sel, i_wait_pin_route_sel, i_rx4_route_sel,
         i_irq_route_sel, i_bt0_compare_out_sel, i_bt1_compare_out_sel,
         i_sci4_rx_on, i_sci4_tx_on, i_iic2_enable, i_adc_trigger_sel,
         i_external_bus_on, i_wait_pin_on} = '0;
        i_byte_timer_route_sel = 1'b1;
        i_adc_ext_trigger_sel = 1'b1;
        i_single_chip_mode = 1'b1;
        ext = 8'($urandom);
        i_latch = 8'($urandom);
    endtask : clear
    task automatic fresh;
        shuffle = 1'b1;
        @(negedge i_sys_clk);
        shuffle = 1'b0;
        clear;
    endtask : fresh
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // processes
    // ------------------------------------------------------------
    // 20 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    // result watcher: every queued note, oldest first, against the outputs
    initial begin : monitor
        ppm_note_t n;
        forever begin
            @(sample_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                if (n.kind == 0) cmp_pins(n);
                else cmp_ins(n);
            end
        end
    end
    // hang guard
    initial begin : watchdog
        #100000;
        bad_count++;
        print_verdict;
    end
    // stimulus
    initial begin : main
        void'($urandom(32'h6faa));
        clr_tab = '{ppm_pkg::CLR_P0, ppm_pkg::CLR_P1, ppm_pkg::CLR_P2,
                    ppm_pkg::CLR_P3};
        oc_tab = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
        i_reset_n = 1'b0;
        shuffle = 1'b0;
        clear;
        repeat (6) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        wp("rst", 8'hff, 8'h00, 8'h00);
        wi("rst_in", 16'hffff, 16'h0610);
        -> sample_ev;
        i_reset_n = 1'b1;
        fresh;
        i_direction = 8'hff;
        wp("latch", 8'hff, i_latch, 8'hff);
        settle;
        i_pattern_bit_enable = 8'hff;
        wp("pattern", 8'hff, i_pattern_out, 8'hff);
        settle;
        i_pattern_route_sel = 1'b1;
        wp("proute", 8'hff, i_latch, 8'hff);
        settle;
        i_pattern_route_sel = 1'b0;
        i_pattern_bit_enable = 8'h00;
        i_drain_select = 8'hff;
        wp("drain", 8'hff, 8'h00, ~i_latch);
        settle;
        foreach (oc_tab[i]) begin
            fresh;
            {i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d} = {4{oc_tab[i]}};
            {i_t4_io_a, i_t4_io_b, i_t5_io_a, i_t5_io_b} = {4{oc_tab[i]}};
            wp("compare", 8'hff,
               {i_t5_out, i_t4_out, i_t3_out}, 8'hff);
            settle;
        end
        i_timer_route_sel = 1'b1;
        wp("troute", 8'hff, 8'h00, 8'h00);
        settle;
        for (int k = 0; k < 4; k++) begin
            fresh;
            i_t3_mode = ppm_pkg::MODE_PWM2;
            {i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d} = 16'h1111;
            i_t3_clr = clr_tab[k];
            wp("pwm2", 8'h0f, {4'h0, i_t3_out},
               8'h0f ^ (8'h01 << k));
            settle;
        end
        {i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d} = 16'h4444;
        wp("xx00", 8'h0f, 8'h00, 8'h00);
        settle;
        fresh;
        i_t3_mode = ppm_pkg::MODE_PWM1;
        i_t5_mode = ppm_pkg::MODE_PWM1;
        {i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d} = 16'h1111;
        {i_t5_io_a, i_t5_io_b} = 8'h11;
        wp("pwm1", 8'hcf, {1'b0, i_t5_out[0], 3'h0, i_t3_out[2], 1'b0,
           i_t3_out[0]}, 8'h45);
        settle;
        i_t3_buf_a = 1'b1;
        wp("buffer", 8'h05, {7'h00, i_t3_out[0]}, 8'h01);
        settle;
        fresh;
        {i_t3_io_a, i_t3_io_b, i_t3_io_c, i_t3_io_d} = 16'h8888;
        {i_t4_mode, i_t4_io_a, i_t5_mode, i_t5_io_b} = 16'h4858;
        {i_t4_io_b, i_t5_io_a} = 8'h88;
        wi("capture", 16'hf988, {ext[2:0], ext[5], ext[6], 2'h0,
           ext[4], ext[7], 3'h0, ext[3], 3'h0});
        settle;
        i_t3_mode = 4'h4;
        wi("cap_d", 16'he008, 16'h0000);
        settle;
        fresh;
        i_irq_route_sel = 3'($urandom);
        i_adc_ext_trigger_sel = 1'b0;
        i_adc_trigger_sel = 2'b11;
        wi("irq", 16'h0007, {13'h0, ext[2:0] & i_irq_route_sel});
        wi("adc", 16'h0040, {9'h0, ext[6], 6'h0});
        settle;
        i_adc_trigger_sel = 2'b01;
        wi("adc_off", 16'h0040, 16'h0000);
        settle;
        fresh;
        i_direction = 8'hff;
        i_sci4_rx_on = 1'b1;
        i_sci4_tx_on = 1'b1;
        wp("serial", 8'h18, {4'h0, i_serial4_tx_line, 3'h0}, 8'h08);
        wi("rx", 16'h0010, {11'h0, ext[4], 4'h0});
        settle;
        i_rx4_route_sel = 1'b1;
        wi("rx_route", 16'h0010, 16'h0010);
        settle;
        i_byte_timer_route_sel = 1'b0;
        i_bt0_compare_out_sel = 4'h1;
        i_bt1_compare_out_sel = 4'h8;
        wp("bytetimer", 8'h30, {2'h0, i_bytetimer_out, 4'h0},
           8'h30);
        settle;
        i_t4_io_b = 4'h1;
        wp("bt_timer", 8'h20, {2'h0, i_t4_out[1], 5'h0}, 8'h20);
        settle;
        i_single_chip_mode = 1'b0;
        i_wait_pin_on = 1'b1;
        i_wait_pin_route_sel = 1'b1;
        wp("wait", 8'h20, 8'h00, 8'h00);
        wi("wait_in", 16'h0020, {10'h0, ext[5], 5'h0});
        settle;
        i_single_chip_mode = 1'b1;
        wp("single", 8'h20, {2'h0, i_t4_out[1], 5'h0}, 8'h20);
        wi("wait_off", 16'h0020, 16'h0000);
        settle;
        i_external_bus_on = 1'b1;
        wp("external_bus_on", 8'h20, 8'h00, 8'h00);
        wi("external_bus_on_in", 16'h0020, {10'h0, ext[5], 5'h0});
        settle;
        repeat (4) begin
            fresh;
            i_direction = 8'hff;
            i_iic2_enable = 1'b1;
            wp("iic", 8'hc0, 8'h00,
               {~i_scl_out, ~i_sda_out, 6'h0});
            wi("iic_in", 16'h0600, {5'h0, i_sda_out & ext[6],
               i_scl_out & ext[7], 9'h0});
            settle;
        end
        print_verdict;
    end
endmodule : tb
`default_nettype wire
